// >>> core/cmpctl_params.svh
`ifndef CMPCTL_PARAMS_SVH
`define CMPCTL_PARAMS_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define CMPCTL_IDX_CTRL_A 8'h0a
`define CMPCTL_IDX_CTRL_B 8'h0b
`define CMPCTL_IDX_BUF_OFF 8'h0c

// =====================================================================
// control a fields
`define CMPCTL_A_POWER_OFF 7
`define CMPCTL_A_POS_MSB 6
`define CMPCTL_A_RESULT 5
`define CMPCTL_A_FLAG 4
`define CMPCTL_A_IRQ_EN 3
`define CMPCTL_A_ROUTE 2
`define CMPCTL_A_TRIG_HI 1
`define CMPCTL_A_TRIG_LO 0

// =====================================================================
// control b fields
`define CMPCTL_B_HYST_ON 7
`define CMPCTL_B_HYST_LEVEL 6
`define CMPCTL_B_PIN_EN 4
`define CMPCTL_B_NEG_HI 3
`define CMPCTL_B_NEG_LO 2
`define CMPCTL_B_POS_HI 1
`define CMPCTL_B_POS_LO 0

// =====================================================================
// buffer disable fields and reset values
`define CMPCTL_D_NEG_OFF 2
`define CMPCTL_D_POS_OFF 1
`define CMPCTL_RST_CTRL_A 8'h00
`define CMPCTL_RST_CTRL_B 8'h00
`define CMPCTL_RST_BUF_OFF 8'h00

`endif

// >>> core/cmpctl_pkg.sv
package cmpctl_pkg;

  // =====================================================================
  // field encodings
  typedef enum logic [1:0] {
    CMPCTL_TRIG_TOGGLE = 2'h0,
    CMPCTL_TRIG_RSVD = 2'h1,
    CMPCTL_TRIG_FALL = 2'h2,
    CMPCTL_TRIG_RISE = 2'h3
  } cmpctl_trig_type;

  typedef enum logic [1:0] {
    CMPCTL_HYST_NONE = 2'h0,
    CMPCTL_HYST_20MV = 2'h1,
    CMPCTL_HYST_50MV = 2'h2
  } cmpctl_hyst_type;

  typedef enum logic [2:0] {
    CMPCTL_POS_PIN = 3'h0,
    CMPCTL_POS_BANDGAP = 3'h4
  } cmpctl_pos_type;

  typedef enum logic [1:0] {
    CMPCTL_NEG_PIN = 2'h0,
    CMPCTL_NEG_ADCMUX = 2'h1
  } cmpctl_neg_type;

endpackage

// >>> core/cmpctl_top.sv
`timescale 1ns/1ps
`include "cmpctl_params.svh"

// Behaviour
// - result reads one when selected positive input exceeds selected negative input.
// - raw result passes a synchroniser before the status bit; one to two cycles.
// - event flag set when a result change matches the selected trigger.
// - flag cleared by vector acknowledge or writing one; writing zero keeps it.
// - request only while flag, irq enable bit 3 and global enable all set.
// - trigger code 00 toggle, 01 reserved, 10 falling, 11 rising.
// - power-off bit 7 of control a drives the analog power-down control.
// - routing bit 2 feeds synchronised result to timer capture; clear disconnects.
// - pin enable bit 4 of control b drives result onto its output pin.
// - hysteresis off gives none; on, level zero 20 mV, level one 50 mV.
// - negative select 3:2, 00 pin, 01 converter mux, 10 and 11 reserved.
// - positive select msb control a bit 6, low bits b 1:0; 000 pin, 100 bandgap.
// - buffer-off bits 2 and 1 kill pin digital buffers; port bit reads zero.
module cmpctl_top
  import cmpctl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic cmp_raw_i,
  input wire logic irq_ack_i,
  input wire logic global_irq_en_i,
  input wire logic pos_pin_dig_i,
  input wire logic neg_pin_dig_i,
  output logic irq_o,
  output logic power_off_o,
  output logic [2:0] pos_sel_o,
  output logic [1:0] neg_sel_o,
  output logic [1:0] hyst_code_o,
  output logic capture_o,
  output logic result_pin_o,
  output logic result_pin_oe_b_o,
  output logic pos_buf_off_o,
  output logic neg_buf_off_o,
  output logic pos_port_o,
  output logic neg_port_o
);

  // =====================================================================
  // bus slave: writes need no wait, reads take one wait state
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] idx_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic take;
  logic wr_a;
  logic wr_b;
  logic wr_d;

  assign take = hsel_i && htrans_i[1] && hready_i;
  assign wr_a = wr_pend_q && (idx_q == `CMPCTL_IDX_CTRL_A);
  assign wr_b = wr_pend_q && (idx_q == `CMPCTL_IDX_CTRL_B);
  assign wr_d = wr_pend_q && (idx_q == `CMPCTL_IDX_BUF_OFF);

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 8'h00;
      hreadyout_q <= 1'b1;
    end else if (ce_i) begin
      wr_pend_q <= take && hwrite_i;
      rd_pend_q <= take && !hwrite_i;
      if (take) begin
        idx_q <= haddr_i[9:2];
      end
      // read data is built a cycle late so a preceding write is seen
      hreadyout_q <= !(take && !hwrite_i);
    end
  end

  // =====================================================================
  // control registers
  logic power_off_q;
  logic pos_msb_q;
  logic irq_en_q;
  logic route_q;
  cmpctl_trig_type trig_q;
  logic hyst_on_q;
  logic hyst_level_q;
  logic pin_en_q;
  logic [1:0] neg_q;
  logic [1:0] pos_low_q;
  logic pos_off_q;
  logic neg_off_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      power_off_q <= 1'(`CMPCTL_RST_CTRL_A >> `CMPCTL_A_POWER_OFF);
      pos_msb_q <= 1'b0;
      irq_en_q <= 1'b0;
      route_q <= 1'b0;
      trig_q <= CMPCTL_TRIG_TOGGLE;
    end else if (ce_i && wr_a) begin
      power_off_q <= hwdata_i[`CMPCTL_A_POWER_OFF];
      pos_msb_q <= hwdata_i[`CMPCTL_A_POS_MSB];
      irq_en_q <= hwdata_i[`CMPCTL_A_IRQ_EN];
      route_q <= hwdata_i[`CMPCTL_A_ROUTE];
      trig_q <= cmpctl_trig_type'(hwdata_i[`CMPCTL_A_TRIG_HI:`CMPCTL_A_TRIG_LO]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      hyst_on_q <= 1'b0;
      hyst_level_q <= 1'b0;
      pin_en_q <= 1'b0;
      neg_q <= 2'h0;
      pos_low_q <= 2'h0;
    end else if (ce_i && wr_b) begin
      hyst_on_q <= hwdata_i[`CMPCTL_B_HYST_ON];
      hyst_level_q <= hwdata_i[`CMPCTL_B_HYST_LEVEL];
      pin_en_q <= hwdata_i[`CMPCTL_B_PIN_EN];
      neg_q <= hwdata_i[`CMPCTL_B_NEG_HI:`CMPCTL_B_NEG_LO];
      pos_low_q <= hwdata_i[`CMPCTL_B_POS_HI:`CMPCTL_B_POS_LO];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pos_off_q <= 1'b0;
      neg_off_q <= 1'b0;
    end else if (ce_i && wr_d) begin
      pos_off_q <= hwdata_i[`CMPCTL_D_POS_OFF];
      neg_off_q <= hwdata_i[`CMPCTL_D_NEG_OFF];
    end
  end

  // =====================================================================
  // result synchroniser and edge detect
  logic sync1_q;
  logic res_q;
  logic res_prev_q;
  logic rise;
  logic fall;
  logic flag_set;

  // analog core already gives one for positive above negative
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sync1_q <= 1'b0;
      res_q <= 1'b0;
      res_prev_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= cmp_raw_i;
      res_q <= sync1_q;
      res_prev_q <= res_q;
    end
  end

  assign rise = res_q && !res_prev_q;
  assign fall = !res_q && res_prev_q;

  always_comb begin
    case (trig_q)
      CMPCTL_TRIG_TOGGLE: flag_set = rise || fall;
      CMPCTL_TRIG_FALL: flag_set = fall;
      CMPCTL_TRIG_RISE: flag_set = rise;
      default: flag_set = 1'b0;
    endcase
  end

  // =====================================================================
  // event flag and request
  logic flag_q;
  logic flag_clr;
  logic irq_q;

  assign flag_clr = irq_ack_i || (wr_a && hwdata_i[`CMPCTL_A_FLAG]);

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      flag_q <= 1'b0;
    end else if (ce_i) begin
      flag_q <= flag_set || (flag_q && !flag_clr);
    end
  end

  // software must mask the request around trigger or power changes
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= flag_q && irq_en_q && global_irq_en_i;
    end
  end

  // =====================================================================
  // analog controls, capture routing and result pin
  logic power_off_oq;
  logic [2:0] pos_sel_q;
  logic [1:0] neg_sel_q;
  logic [1:0] hyst_q;
  logic capture_q;
  logic pin_q;
  logic pin_oe_b_q;
  logic [2:0] pos_code;

  assign pos_code = {pos_msb_q, pos_low_q};

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      power_off_oq <= 1'b0;
      pos_sel_q <= CMPCTL_POS_PIN;
      neg_sel_q <= CMPCTL_NEG_PIN;
      hyst_q <= CMPCTL_HYST_NONE;
    end else if (ce_i) begin
      power_off_oq <= power_off_q;
      // reserved codes fall back to the pin input
      pos_sel_q <= (pos_code == CMPCTL_POS_BANDGAP) ? CMPCTL_POS_BANDGAP
                                                     : CMPCTL_POS_PIN;
      neg_sel_q <= (neg_q == CMPCTL_NEG_ADCMUX) ? CMPCTL_NEG_ADCMUX
                                                 : CMPCTL_NEG_PIN;
      if (!hyst_on_q) begin
        hyst_q <= CMPCTL_HYST_NONE;
      end else if (hyst_level_q) begin
        hyst_q <= CMPCTL_HYST_50MV;
      end else begin
        hyst_q <= CMPCTL_HYST_20MV;
      end
    end
  end

  // timer capture interrupt enable lives in the timer
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      capture_q <= 1'b0;
      pin_q <= 1'b0;
      pin_oe_b_q <= 1'b1;
    end else if (ce_i) begin
      capture_q <= route_q && res_q;
      pin_q <= pin_en_q && res_q;
      pin_oe_b_q <= !pin_en_q;
    end
  end

  // =====================================================================
  // pin digital buffers
  logic pos_s1_q;
  logic pos_s2_q;
  logic neg_s1_q;
  logic neg_s2_q;
  logic pos_port_q;
  logic neg_port_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pos_s1_q <= 1'b0;
      pos_s2_q <= 1'b0;
      neg_s1_q <= 1'b0;
      neg_s2_q <= 1'b0;
      pos_port_q <= 1'b0;
      neg_port_q <= 1'b0;
    end else if (ce_i) begin
      pos_s1_q <= pos_pin_dig_i;
      pos_s2_q <= pos_s1_q;
      neg_s1_q <= neg_pin_dig_i;
      neg_s2_q <= neg_s1_q;
      pos_port_q <= pos_s2_q && !pos_off_q;
      neg_port_q <= neg_s2_q && !neg_off_q;
    end
  end

  // =====================================================================
  // read data
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx_q)
      `CMPCTL_IDX_CTRL_A: rd_mux[7:0] = {power_off_q, pos_msb_q, res_q, flag_q,
                                         irq_en_q, route_q, trig_q};
      `CMPCTL_IDX_CTRL_B: rd_mux[7:0] = {hyst_on_q, hyst_level_q, 1'b0, pin_en_q,
                                         neg_q, pos_low_q};
      `CMPCTL_IDX_BUF_OFF: rd_mux[7:0] = {5'h00, neg_off_q, pos_off_q, 1'b0};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce_i && rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  assign hreadyout_o = hreadyout_q;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;
  assign irq_o = irq_q;
  assign power_off_o = power_off_oq;
  assign pos_sel_o = pos_sel_q;
  assign neg_sel_o = neg_sel_q;
  assign hyst_code_o = hyst_q;
  assign capture_o = capture_q;
  assign result_pin_o = pin_q;
  assign result_pin_oe_b_o = pin_oe_b_q;
  assign pos_buf_off_o = pos_off_q;
  assign neg_buf_off_o = neg_off_q;
  assign pos_port_o = pos_port_q;
  assign neg_port_o = neg_port_q;

  // =====================================================================
  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_sync_delay: assert property (
    ce_i ##1 ce_i |=> res_q == $past(cmp_raw_i, 2))
    else $error("result bit does not follow raw input after two edges");
  a_rise_sets_flag: assert property (
    (ce_i && trig_q == CMPCTL_TRIG_RISE && res_q && !res_prev_q) |=> flag_q)
    else $error("rising edge did not set flag");
  a_fall_ignored_rise: assert property (
    (ce_i && trig_q == CMPCTL_TRIG_RISE && !flag_q && !res_q) |=> !flag_q)
    else $error("flag set without a rising edge");
  a_reserved_no_flag: assert property (
    (ce_i && trig_q == CMPCTL_TRIG_RSVD && !flag_q) |=> !flag_q)
    else $error("reserved trigger set the flag");
  a_w1c_clears_flag: assert property (
    (ce_i && wr_a && hwdata_i[`CMPCTL_A_FLAG] && !flag_set) |=> !flag_q)
    else $error("write one did not clear flag");
  a_irq_gating: assert property (
    ce_i |=> irq_o == $past(flag_q && irq_en_q && global_irq_en_i))
    else $error("request does not match flag and enables");
  a_capture_gated: assert property (
    (ce_i && !route_q) |=> !capture_o)
    else $error("capture driven while routing off");
  a_pin_enable: assert property (
    (ce_i && pin_en_q) |=> (!result_pin_oe_b_o && result_pin_o == $past(res_q)))
    else $error("result pin not driven while enabled");
  a_hyst_code: assert property (
    (ce_i && hyst_on_q && hyst_level_q) |=> hyst_code_o == CMPCTL_HYST_50MV)
    else $error("hysteresis code wrong for high level");
  a_neg_select: assert property (
    (ce_i && neg_q[1]) |=> neg_sel_o == CMPCTL_NEG_PIN)
    else $error("reserved negative code not mapped to pin");
  a_pos_bandgap: assert property (
    (ce_i && pos_code == CMPCTL_POS_BANDGAP) |=> pos_sel_o == CMPCTL_POS_BANDGAP)
    else $error("bandgap not selected");
  a_power_off: assert property (
    (ce_i && power_off_q) |=> power_off_o)
    else $error("power-off control not driven");
  a_buf_off_zero: assert property (
    (ce_i && neg_off_q) |=> !neg_port_o)
    else $error("port bit not zero with buffer off");
endmodule

// >>> verif/cmpctl_analog_model.sv
`timescale 1ns/1ps

// =====================================================================
// analog comparator core stand-in
module cmpctl_analog_model
  import cmpctl_pkg::*;
(
  input wire logic [2:0] pos_sel_i,
  input wire logic [1:0] neg_sel_i,
  input wire logic power_off_i,
  input wire logic [1:0] hyst_code_i,
  input int pos_pin_mv_i,
  input int bandgap_mv_i,
  input int neg_pin_mv_i,
  input int mux_mv_i,
  output logic cmp_raw_o
);
  int pos_mv;
  int neg_mv;
  int hyst_mv;

  always @* begin
    pos_mv = (pos_sel_i == CMPCTL_POS_BANDGAP) ? bandgap_mv_i : pos_pin_mv_i;
    neg_mv = (neg_sel_i == CMPCTL_NEG_ADCMUX) ? mux_mv_i : neg_pin_mv_i;
    hyst_mv = (hyst_code_i == CMPCTL_HYST_50MV) ? 50 :
              (hyst_code_i == CMPCTL_HYST_20MV) ? 20 : 0;
  end

  // inside the band the output holds, as a real hysteresis loop does
  initial cmp_raw_o = 1'b0;
  always @* begin
    if (power_off_i) begin
      cmp_raw_o = 1'b0;
    end else if (2 * pos_mv > 2 * neg_mv + hyst_mv) begin
      cmp_raw_o = 1'b1;
    end else if (2 * pos_mv <= 2 * neg_mv - hyst_mv) begin
      cmp_raw_o = 1'b0;
    end
  end
endmodule

// >>> verif/cmpctl_tb_top.sv
`timescale 1ns/1ps
`include "cmpctl_params.svh"
`define CMPCTL_CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, (g), (e)); end end

module cmpctl_tb_top;
  localparam logic [31:0] A_ADR = {22'h0, `CMPCTL_IDX_CTRL_A, 2'b00};
  localparam logic [31:0] B_ADR = {22'h0, `CMPCTL_IDX_CTRL_B, 2'b00};
  localparam logic [31:0] D_ADR = {22'h0, `CMPCTL_IDX_BUF_OFF, 2'b00};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic irq_ack = 1'b0;
  logic gie = 1'b0;
  logic pos_dig = 1'b0;
  logic neg_dig = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, irq, pwr_off, capture, rpin, rpin_oe_b, pbo, nbo, pport, nport, raw;
  logic [31:0] hrdata;
  logic [2:0] pos_sel;
  logic [1:0] neg_sel, hyst;
  int pos_mv = 400;
  int neg_mv = 500;
  int bandgap_mv = 1100;
  int mux_mv = 300;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] ta [6] = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h40, 8'h00};
  logic [7:0] tb [6] = '{8'h00, 8'h40, 8'h84, 8'hc8, 8'h01, 8'h2f};
  logic [2:0] tp [6] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h0};
  logic [1:0] tn [6] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
  logic [1:0] th [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0};

  always #25 clk = ~clk;

  cmpctl_top i_dut (.core_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .cmp_raw_i(raw), .irq_ack_i(irq_ack), .global_irq_en_i(gie),
    .pos_pin_dig_i(pos_dig), .neg_pin_dig_i(neg_dig), .irq_o(irq), .power_off_o(pwr_off),
    .pos_sel_o(pos_sel), .neg_sel_o(neg_sel), .hyst_code_o(hyst), .capture_o(capture),
    .result_pin_o(rpin), .result_pin_oe_b_o(rpin_oe_b), .pos_buf_off_o(pbo),
    .neg_buf_off_o(nbo), .pos_port_o(pport), .neg_port_o(nport));

  cmpctl_analog_model i_model (.pos_sel_i(pos_sel), .neg_sel_i(neg_sel),
    .power_off_i(pwr_off), .hyst_code_i(hyst), .pos_pin_mv_i(pos_mv),
    .bandgap_mv_i(bandgap_mv), .neg_pin_mv_i(neg_mv), .mux_mv_i(mux_mv), .cmp_raw_o(raw));

  // =====================================================================
  // bus master: entered and left right at a rising edge
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] wd,
                      output logic [31:0] rd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(a, 1'b0, 8'h00, r);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] r;
    rd(A_ADR, r); `CMPCTL_CHK(r, 32'h0)
    rd(B_ADR, r); `CMPCTL_CHK(r, 32'h0)
    rd(D_ADR, r); `CMPCTL_CHK(r, 32'h0)
    `CMPCTL_CHK(rpin_oe_b, 1'b1)
    `CMPCTL_CHK(irq, 1'b0)
    wr(32'h34, 8'hff);
    rd(32'h34, r); `CMPCTL_CHK(r, 32'h0)
    `CMPCTL_CHK(hresp, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_mux;
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      wr(A_ADR, ta[i]); // irq enable stays low while power bit moves
      wr(B_ADR, tb[i]);
      wait_clk(2);
      `CMPCTL_CHK(pos_sel, tp[i])
      `CMPCTL_CHK(neg_sel, tn[i])
      `CMPCTL_CHK(hyst, th[i])
      `CMPCTL_CHK(pwr_off, ta[i][7])
      rd(B_ADR, r); `CMPCTL_CHK(r[7:0], tb[i] & 8'hdf)
    end
    wr(A_ADR, 8'h00);
    wr(B_ADR, 8'h00);
    $display("test mux done");
  endtask

  task automatic t_edges;
    logic [31:0] r;
    for (int t = 0; t < 4; t++) begin
      wr(A_ADR, 8'h10 | t[1:0]); // trigger changed with irq enable low
      pos_mv <= 600;
      wait_clk(6);
      rd(A_ADR, r); `CMPCTL_CHK(r[5], 1'b1)
      `CMPCTL_CHK(r[4], (t == 0 || t == 3))
      wr(A_ADR, {6'h0, t[1:0]});
      rd(A_ADR, r); `CMPCTL_CHK(r[4], (t == 0 || t == 3))
      wr(A_ADR, 8'h10 | t[1:0]);
      rd(A_ADR, r); `CMPCTL_CHK(r[4], 1'b0)
      pos_mv <= 400;
      wait_clk(6);
      rd(A_ADR, r); `CMPCTL_CHK(r[5], 1'b0)
      `CMPCTL_CHK(r[4], (t == 0 || t == 2))
    end
    wr(A_ADR, 8'h10);
    $display("test edges done");
  endtask

  task automatic t_route;
    int n;
    wr(A_ADR, 8'h04); // capture interrupt enable belongs to the timer
    wr(B_ADR, 8'h10);
    wait_clk(2);
    `CMPCTL_CHK(rpin_oe_b, 1'b0)
    pos_mv <= 600;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (capture !== 1'b1 && n < 10);
    `CMPCTL_CHK(n, 3)
    `CMPCTL_CHK(rpin, 1'b1)
    @(posedge clk);
    wr(A_ADR, 8'h10);
    wr(B_ADR, 8'h00);
    wait_clk(2);
    `CMPCTL_CHK(capture, 1'b0)
    `CMPCTL_CHK(rpin, 1'b0)
    `CMPCTL_CHK(rpin_oe_b, 1'b1)
    pos_mv <= 400;
    wait_clk(6);
    $display("test route done");
  endtask

  task automatic t_irq;
    logic [31:0] r;
    gie <= 1'b1;
    wr(A_ADR, 8'h13); // rising trigger set before enabling
    wr(A_ADR, 8'h0b);
    pos_mv <= 600;
    wait_clk(6);
    `CMPCTL_CHK(irq, 1'b1)
    gie <= 1'b0;
    wait_clk(2);
    `CMPCTL_CHK(irq, 1'b0)
    gie <= 1'b1;
    wait_clk(2);
    `CMPCTL_CHK(irq, 1'b1)
    wr(A_ADR, 8'h03);
    wait_clk(2);
    `CMPCTL_CHK(irq, 1'b0)
    wr(A_ADR, 8'h0b);
    wait_clk(2);
    `CMPCTL_CHK(irq, 1'b1)
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    wait_clk(2);
    `CMPCTL_CHK(irq, 1'b0)
    rd(A_ADR, r); `CMPCTL_CHK(r[4], 1'b0)
    wr(A_ADR, 8'h03);
    pos_mv <= 400;
    wait_clk(6);
    $display("test irq done");
  endtask

  task automatic t_buf;
    logic [31:0] r;
    pos_dig <= 1'b1;
    neg_dig <= 1'b1;
    wait_clk(4);
    `CMPCTL_CHK({pport, nport}, 2'h3)
    wr(D_ADR, 8'hff);
    rd(D_ADR, r); `CMPCTL_CHK(r, 32'h6)
    wait_clk(2);
    `CMPCTL_CHK({pbo, nbo, pport, nport}, 4'hc)
    wr(D_ADR, 8'h04);
    wait_clk(4);
    `CMPCTL_CHK({pbo, nbo, pport, nport}, 4'h6)
    $display("test buffers done");
  endtask

  // low enable must freeze the pin synchronisers and port bits
  task automatic t_ce;
    ce <= 1'b0;
    pos_dig <= 1'b0;
    wait_clk(4);
    `CMPCTL_CHK(pport, 1'b1)
    ce <= 1'b1;
    wait_clk(4);
    `CMPCTL_CHK(pport, 1'b0)
    $display("test clock enable done");
  endtask

  // =====================================================================
  // verdict
  task automatic wrap_up;
    $display("checks %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // generous: the whole sequence takes well under two thousand cycles
  initial begin
    wait_clk(20000);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up;
  end

  initial begin
    wait_clk(10);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_mux;
    t_edges;
    t_route;
    t_irq;
    t_buf;
    t_ce;
    wrap_up;
  end
endmodule
